// File: tb/lcdcd_checker.sv
// Port-level assertions for the LCD command decoder
module lcdcd_checker
  import lcdcd_pkg::*;
#(
  parameter int PTR_W = 7
) (
  input logic             clk_i,
  input logic             rst_b_i,
  input logic             rx_valid_i,
  input logic             rx_ready_o,
  input logic [7:0]       rx_byte_i,
  input logic             ack_output_pad_o,
  input logic             ram_wr_valid_o,
  input logic             ram_wr_ready_i,
  input logic [PTR_W-1:0] ram_wr_addr_o,
  input logic [7:0]       ram_wr_data_o,
  input logic             display_enable_o,
  input logic             bias_half_o,
  input logic [1:0]       drive_mode_o,
  input logic             output_bank_o,
  input logic [1:0]       blink_rate_o,
  input logic             blink_phase_o,
  input logic [PTR_W-1:0] ram_pointer_o,
  input logic [1:0]       backplane_out_o,
  input logic             sync_i,
  input logic             sync_o,
  input logic             sync_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Handshake and settings only move on an accepted byte
  a_ack_cause: assert property (ack_output_pad_o |-> $past(rx_valid_i && rx_ready_o))
    else $error("acknowledge without accepted byte");
  a_mode_cause: assert property ($changed(drive_mode_o) |-> $past(rx_valid_i && rx_ready_o))
    else $error("drive mode moved without a byte");
  a_mode_decode: assert property ($changed({display_enable_o, bias_half_o, drive_mode_o}) |->
    {display_enable_o, bias_half_o, drive_mode_o} == $past(rx_byte_i[3:0]))
    else $error("mode fields differ from command byte");
  a_bank_ignore: assert property ((drive_mode_o == LCDCD_MUX3 || drive_mode_o == LCDCD_MUX4) |=>
    $stable(output_bank_o))
    else $error("bank moved in a high multiplex mode");
  a_ptr_range: assert property (ram_pointer_o < 80)
    else $error("pointer beyond last location");
  // Sync pad: pull low only, at the last backplane, realign on a foreign pull
  a_sync_last: assert property (sync_oe_o == (backplane_out_o == drive_mode_o - 2'h1))
    else $error("sync drive not on last backplane");
  a_sync_low: assert property (sync_o == 1'b0)
    else $error("sync pad driven high");
  a_sync_align: assert property ($fell(sync_i) && !sync_oe_o |-> ##[1:2]
    backplane_out_o == drive_mode_o - 2'h1)
    else $error("no realign to foreign sync");
  a_blink_off: assert property (blink_rate_o == 2'h0 [*2] |-> blink_phase_o == 1'b0)
    else $error("blink phase runs with blinking off");
  // A stalled write must keep its word, or the buffer loses data
  a_ram_hold: assert property (ram_wr_valid_o && !ram_wr_ready_i |=> ram_wr_valid_o &&
    $stable({ram_wr_addr_o, ram_wr_data_o}))
    else $error("stalled RAM write changed");
endmodule // lcdcd_checker

bind lcdcd_decoder lcdcd_checker #(.PTR_W(PTR_W)) u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .rx_byte_i(rx_byte_i),
  .ack_output_pad_o(ack_output_pad_o), .ram_wr_valid_o(ram_wr_valid_o), .ram_wr_ready_i(ram_wr_ready_i),
  .ram_wr_addr_o(ram_wr_addr_o), .ram_wr_data_o(ram_wr_data_o), .display_enable_o(display_enable_o),
  .bias_half_o(bias_half_o), .drive_mode_o(drive_mode_o), .output_bank_o(output_bank_o),
  .blink_rate_o(blink_rate_o), .blink_phase_o(blink_phase_o), .ram_pointer_o(ram_pointer_o),
  .backplane_out_o(backplane_out_o), .sync_i(sync_i), .sync_o(sync_o), .sync_oe_o(sync_oe_o));

// File: tb/lcdcd_peer.sv
// Cascade neighbour on the sync line and slow RAM write consumer
module lcdcd_peer (
  input  logic clk_i,
  input  logic pull_i,
  input  logic stall_i,
  output logic oe_o,
  output logic ready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt = 2'h0;
  // Neighbour only ever pulls the shared line low, when it asserts first
  assign oe_o = pull_i;
  // Slow mode takes one word in four so the buffer fills up
  always @(posedge clk_i) cnt <= cnt + 2'h1;
  assign ready_o = !stall_i || (cnt == 2'h0);
endmodule // lcdcd_peer

// File: tb/test_lcd_driver_command_decoder.sv
// Self-checking bench for the LCD command decoder
module test_lcd_driver_command_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0, rst_b_i = 1'b0, disp_tick_i = 1'b0, pin = 1'b0, tick_en = 1'b0;
  logic        rx_start_i = 1'b0, rx_stop_i = 1'b0, rx_valid_i = 1'b0, pull = 1'b0, stall = 1'b0;
  logic [7:0]  rx_byte_i = 8'h00;
  logic        rx_ready_o, ack_o, wv, wr, wb, en, bias, ob, alt, bph, s_o, s_oe, p_oe;
  logic [1:0]  mode, rate, bp;
  logic [6:0]  wa, ptr;
  logic [7:0]  wd;
  logic [2:0]  sub;
  wire         sync_i = !(s_oe || p_oe);
  int          n_errors = 0, comparisons = 0, n_ack = 0, n_refuse = 0, n_tick = 0, n;
  logic [15:0] wq[$];
  localparam logic [21:0] RST_V = {1'b0, 1'b1, 2'h0, 4'h1, 7'h00, 3'h0, 4'h0};
  // Command byte beside {enable, bias, mode, pointer, subaddress, rate, alternate, output bank}
  logic [25:0] rows [17] = '{{8'hCE, 4'hE, 7'h00, 3'h0, 4'h0}, {8'h2A, 4'hE, 7'h2A, 3'h0, 4'h0},
    {8'hE5, 4'hE, 7'h2A, 3'h5, 4'h0}, {8'hFB, 4'hE, 7'h2A, 3'h5, 4'h1}, {8'hF7, 4'hE, 7'h2A, 3'h5, 4'hF},
    {8'hF2, 4'hE, 7'h2A, 3'h5, 4'h9}, {8'hF1, 4'hE, 7'h2A, 3'h5, 4'h5}, {8'hF0, 4'hE, 7'h2A, 3'h5, 4'h1},
    {8'hC3, 4'h3, 7'h2A, 3'h5, 4'h1}, {8'hF8, 4'h3, 7'h2A, 3'h5, 4'h1}, {8'hF6, 4'h3, 7'h2A, 3'h5, 4'h9},
    {8'hC4, 4'h4, 7'h2A, 3'h5, 4'h9}, {8'hF9, 4'h4, 7'h2A, 3'h5, 4'h9}, {8'hE8, 4'h4, 7'h2A, 3'h5, 4'h9},
    {8'hFC, 4'h4, 7'h2A, 3'h5, 4'h9}, {8'hC5, 4'h5, 7'h2A, 3'h5, 4'hB}, {8'hFA, 4'h5, 7'h2A, 3'h5, 4'hA}};
  lcdcd_decoder #(.DIV_2HZ(4)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .disp_tick_i(disp_tick_i), .slave_addr_low_pin_i(pin),
    .hw_subaddr_i(3'h0), .rx_start_i(rx_start_i), .rx_stop_i(rx_stop_i), .rx_valid_i(rx_valid_i),
    .rx_ready_o(rx_ready_o), .rx_byte_i(rx_byte_i), .ack_output_pad_o(ack_o), .ram_wr_valid_o(wv),
    .ram_wr_ready_i(wr), .ram_wr_addr_o(wa), .ram_wr_data_o(wd), .ram_wr_bank_o(wb),
    .display_enable_o(en), .bias_half_o(bias), .drive_mode_o(mode), .output_bank_o(ob),
    .blink_rate_o(rate), .blink_alternate_o(alt), .blink_phase_o(bph), .ram_pointer_o(ptr),
    .subaddr_count_o(sub), .backplane_out_o(bp), .sync_i(sync_i), .sync_o(s_o), .sync_oe_o(s_oe));
  lcdcd_peer u_peer (.clk_i(clk_i), .pull_i(pull), .stall_i(stall), .oe_o(p_oe), .ready_o(wr));
  initial forever #10 clk_i = ~clk_i;
  // Display tick every fourth cycle; monitors count acks, refusals and RAM writes
  always @(posedge clk_i) begin
    n_tick <= n_tick + 1;
    disp_tick_i <= #2 tick_en && (n_tick % 4 == 0);
    if (ack_o === 1'b1) n_ack <= n_ack + 1;
    if (rx_valid_i === 1'b1 && rx_ready_o === 1'b0) n_refuse <= n_refuse + 1;
    if (wv === 1'b1 && wr === 1'b1) wq.push_back({wb, wa, wd});
  end
  task automatic tk;
    @(posedge clk_i);
    #2;
  endtask
  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [17:0] stat();
    return {en, bias, mode, ptr, sub, rate, alt, ob};
  endfunction
  // Byte is held until the edge that sees ready high; valid stays up for back-to-back bytes
  task automatic send(input logic [7:0] b);
    int k;
    k = 0;
    rx_valid_i = 1'b1;
    rx_byte_i = b;
    while (rx_ready_o !== 1'b1 && k < 100) begin
      tk;
      k++;
    end
    tk;
  endtask
  task automatic stop_rx;
    rx_valid_i = 1'b0;
    rx_stop_i = 1'b1;
    tk;
    rx_stop_i = 1'b0;
  endtask
  task automatic frame(input logic [7:0] addr);
    rx_start_i = 1'b1;
    tk;
    rx_start_i = 1'b0;
    send(addr);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    n_errors++;
    give_verdict;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    #2 rst_b_i = 1'b1;
    chk({wv, s_oe, bp, stat()}, RST_V);
    $display("reset test done");
    frame(8'h70);
    send(8'h00);
    foreach (rows[i]) begin
      send(rows[i][25:18]);
      chk(stat(), rows[i][17:0]);
    end
    stop_rx;
    tk;
    chk(26'(n_ack), 26'd19);
    $display("command table test done");
    frame(8'h72);
    send(8'h00);
    send(8'hC9);
    stop_rx;
    tk;
    chk({8'(n_ack), stat()}, {8'd19, rows[16][17:0]});
    pin = 1'b1;
    stall = 1'b1;
    frame(8'h72);
    send(8'h80);
    send(8'h4B);
    send(8'h80);
    send(8'hE0);
    send(8'h40);
    for (int k = 0; k < 5; k++) send(8'(160 + k));
    stop_rx;
    for (n = 0; n < 100 && wq.size() < 5; n++) tk;
    chk(26'(wq.size()), 26'd5);
    foreach (wq[k]) chk(wq[k], {1'b1, 7'(75 + k), 8'(160 + k)});
    chk({ptr, sub, n_refuse > 0}, {7'h00, 3'h1, 1'b1});
    $display("data and buffer test done");
    frame(8'h72);
    send(8'h00);
    send(8'hC8);
    stop_rx;
    tick_en = 1'b1;
    repeat (40) tk;
    for (n = 0; n < 40 && bp !== 2'h0; n++) tk;
    tick_en = 1'b0;
    tk;
    pull = 1'b1;
    tk;
    pull = 1'b0;
    repeat (3) tk;
    chk({bp, s_oe}, {2'h3, 1'b1});
    $display("sync test done");
    rst_b_i = 1'b0;
    tk;
    chk({wv, s_oe, bp, stat()}, RST_V);
    rst_b_i = 1'b1;
    tk;
    $display("second reset test done");
    give_verdict;
  end
endmodule // test_lcd_driver_command_decoder

// File: verilog/lcdcd_decoder.sv
// Command decoder, display controller status and cascade sync for the LCD driver
`include "lcdcd_map.svh"

// Notes on behaviour
// - 1100 opcode sets enable, bias, mode
// - Mode bits pick backplane count
// - Bias bit: 0 third, 1 half
// - Enable bit 0 blanks display
// - MSB clear loads seven-bit RAM pointer
// - 11100 opcode loads subaddress counter
// - Input bank bit routes incoming data
// - Output bank bit selects displayed bits
// - Bank command ignored in 1:3, 1:4
// - 11110 opcode sets blink rate
// - Blink style selects alternation blinking
// - Normal blinking forced in 1:3, 1:4
// - Execute commands, hold settings, write RAM
// - Assert sync at last backplane onset
// - Realign to first sync assertion seen
// - Sync line is open-drain, pull low
// - Synchronised after reset without command
// - Subaddress plus address bit identify device
// - Control byte selects data or command
// - Data stored at pointer, both advance
// - Answer writes to own address only
module lcdcd_decoder
  import lcdcd_pkg::*;
#(
  parameter int PTR_W   = 7,
  parameter int DIV_2HZ = `LCDCD_DIV_2HZ
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             disp_tick_i,
  input  wire logic             slave_addr_low_pin_i,
  input  wire logic [2:0]       hw_subaddr_i,
  input  wire logic             rx_start_i,
  input  wire logic             rx_stop_i,
  input  wire logic             rx_valid_i,
  output      logic             rx_ready_o,
  input  wire logic [7:0]       rx_byte_i,
  output      logic             ack_output_pad_o,
  output      logic             ram_wr_valid_o,
  input  wire logic             ram_wr_ready_i,
  output      logic [PTR_W-1:0] ram_wr_addr_o,
  output      logic [7:0]       ram_wr_data_o,
  output      logic             ram_wr_bank_o,
  output      logic             display_enable_o,
  output      logic             bias_half_o,
  output      logic [1:0]       drive_mode_o,
  output      logic             output_bank_o,
  output      logic [1:0]       blink_rate_o,
  output      logic             blink_alternate_o,
  output      logic             blink_phase_o,
  output      logic [PTR_W-1:0] ram_pointer_o,
  output      logic [2:0]       subaddr_count_o,
  output      logic [1:0]       backplane_out_o,
  input  wire logic             sync_i,
  output      logic             sync_o,
  output      logic             sync_oe_o
);

  // Overview of the intake path
  // A transfer opens with a start pulse from the bit receiver. The first byte is the
  // address: six fixed bits, the level of the address pin, and a write bit. Any other
  // address, including a read, parks the framing in the ignore state until the next
  // start, so a device on the other address never disturbs its settings.
  // The byte after the address is a control byte. Its top bit says whether another
  // control byte follows the next byte; the bit below says whether the next byte is
  // display data or a command. With the top bit clear every later byte of the frame
  // is of the same kind, which is how a long run of display data is streamed.
  //
  // Commands
  // Commands are decoded by their leading bits only and executed on the clock edge
  // that accepts the byte, so a setting is visible one cycle after its byte. Bytes
  // that match no pattern fall through every decoder and leave all state alone.
  // The bank command is dropped whole in the 1:3 and 1:4 modes, both of its bits.
  // The alternation flag is stored as written but only shown while a mode with a
  // spare bank is active; a later mode change therefore brings it back.
  //
  // Display data
  // Each data byte goes to the location named by the pointer and the subaddress
  // counter, and both advance whether or not this device keeps the byte. Only the
  // device whose pins match the counter keeps it and acknowledges it.
  // A two-entry buffer sits in front of the RAM port. Intake is refused while it is
  // full, so a slow RAM port stalls the receiver rather than losing a word.
  //
  // Cascade sync
  // The backplane sequencer starts at phase 0 on reset in every device, so a cascade
  // released by one reset is aligned without any command. The shared line is only
  // ever pulled low, during this device's last phase. A low seen while not pulling
  // means a neighbour reached its last phase first; the phase jumps there to follow.
  // Limitation: only the first cycle of a foreign low realigns, so a neighbour that
  // holds the line low for long does not keep resetting the phase.
  //
  // Parameter checks
  // The pointer width is fixed by the eighty locations; the blink divider must be
  // at least two so that half a blink period is at least one tick.
  if (PTR_W != 7) begin : g_bad_ptr_w
    $error("lcdcd_decoder: PTR_W must be 7");
  end
  if (DIV_2HZ < 2) begin : g_bad_div
    $error("lcdcd_decoder: DIV_2HZ too small");
  end

  lcdcd_state_t     state;
  logic             more_ctrl;
  logic             is_data;
  logic             in_bank;
  logic             sel_match;
  logic [1:0]       bp_phase;
  logic [13:0]      blink_cnt;
  logic             buf_full0;
  logic             buf_full1;
  logic [PTR_W-1:0] buf_addr0;
  logic [PTR_W-1:0] buf_addr1;
  logic [7:0]       buf_data0;
  logic [7:0]       buf_data1;
  logic             buf_bank0;
  logic             buf_bank1;
  logic             take;
  logic             data_take;
  logic             low_mux;
  logic [1:0]       last_phase;
  logic             sync_seen;
  logic             alt_store;

  // Highest backplane index for the active mode
  function automatic logic [1:0] lcdcd_last(input logic [1:0] m);
    case (m)
      LCDCD_STATIC: lcdcd_last = 2'h0;
      LCDCD_MUX2:   lcdcd_last = 2'h1;
      LCDCD_MUX3:   lcdcd_last = 2'h2;
      default:      lcdcd_last = 2'h3;
    endcase
  endfunction

  // Bytes are refused while the data buffer is full so no display byte is lost
  assign rx_ready_o = !buf_full1;
  assign take       = rx_valid_i && rx_ready_o;
  assign low_mux    = (drive_mode_o == LCDCD_STATIC) || (drive_mode_o == LCDCD_MUX2);
  assign data_take  = take && (state == LCDCD_ST_BODY) && is_data;
  assign last_phase = lcdcd_last(drive_mode_o);

  // Transfer framing: address, control byte, then command or data bytes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state     <= LCDCD_ST_IGNORE;
      more_ctrl <= 1'b0;
      is_data   <= 1'b0;
    end else if (rx_start_i) begin
      state <= LCDCD_ST_ADDR;
    end else if (rx_stop_i) begin
      state <= LCDCD_ST_IGNORE;
    end else if (take) begin
      case (state)
        LCDCD_ST_ADDR: begin
          // Write to own address only, reads and the other address ignored
          if (rx_byte_i == {`LCDCD_ADDR_BASE, slave_addr_low_pin_i, 1'b0})
            state <= LCDCD_ST_CTRL;
          else
            state <= LCDCD_ST_IGNORE;
        end
        LCDCD_ST_CTRL: begin
          more_ctrl <= rx_byte_i[7];  // Another control byte follows
          is_data   <= rx_byte_i[6];  // Next byte is RAM data
          state     <= LCDCD_ST_BODY;
        end
        LCDCD_ST_BODY: begin
          if (more_ctrl) state <= LCDCD_ST_CTRL;
        end
        default: state <= LCDCD_ST_IGNORE;
      endcase
    end
  end

  // Acknowledge: all addressed devices for commands, matched subaddress for data
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_output_pad_o <= 1'b0;
    end else begin
      ack_output_pad_o <= take && ((state == LCDCD_ST_ADDR &&
                            rx_byte_i == {`LCDCD_ADDR_BASE, slave_addr_low_pin_i, 1'b0}) ||
                            state == LCDCD_ST_CTRL || (state == LCDCD_ST_BODY && (!is_data || sel_match)));
    end
  end
  assign sel_match = (subaddr_count_o == hw_subaddr_i);  // Identity is subaddress plus address bit

  // Mode set command
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      display_enable_o <= 1'b0;
      bias_half_o      <= 1'b0;
      drive_mode_o     <= `LCDCD_RST_MODE;
    end else if (take && state == LCDCD_ST_BODY && !is_data && rx_byte_i[7:4] == `LCDCD_OP_MODE) begin
      display_enable_o <= rx_byte_i[3];   // Zero blanks the display
      bias_half_o      <= rx_byte_i[2];   // Zero third, one half
      drive_mode_o     <= rx_byte_i[1:0]; // drive_mode_hi, drive_mode_lo
    end
  end

  // Pointer and subaddress: loaded by command, advanced by each data byte
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ram_pointer_o   <= '0;
      subaddr_count_o <= 3'h0;
    end else if (take && state == LCDCD_ST_BODY) begin
      if (is_data) begin
        // Wrap past the last location into the next device
        if (ram_pointer_o == `LCDCD_RAM_LOCS - 7'h01) begin
          ram_pointer_o   <= '0;
          subaddr_count_o <= subaddr_count_o + 3'h1;
        end else begin
          ram_pointer_o <= ram_pointer_o + 7'h01;
        end
      end else if (!rx_byte_i[7]) begin
        ram_pointer_o <= rx_byte_i[6:0];  // ram_pointer_msb down to bit 0
      end else if (rx_byte_i[7:3] == `LCDCD_OP_DEVSEL) begin
        subaddr_count_o <= rx_byte_i[2:0];  // hw_subaddr_msb down to bit 0
      end
      // Other patterns leave everything unchanged
    end
  end

  // Bank select, dropped entirely in the 1:3 and 1:4 modes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      in_bank       <= 1'b0;
      output_bank_o <= 1'b0;
    end else if (take && state == LCDCD_ST_BODY && !is_data &&
                 rx_byte_i[7:2] == `LCDCD_OP_BANK && low_mux) begin
      in_bank       <= rx_byte_i[1];  // Storage bank for arriving data
      output_bank_o <= rx_byte_i[0];  // Bank shown on the display
    end
  end

  // Blink command
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      blink_rate_o      <= `LCDCD_RST_RATE;
      alt_store         <= 1'b0;
    end else if (take && state == LCDCD_ST_BODY && !is_data && rx_byte_i[7:3] == `LCDCD_OP_BLINK) begin
      blink_rate_o      <= rx_byte_i[1:0];  // blink_rate_hi, blink_rate_lo
      alt_store         <= rx_byte_i[2];
    end
  end

  // Alternation needs a spare bank, so the 1:3 and 1:4 modes fall back to normal
  assign blink_alternate_o = alt_store && low_mux;

  // Blink phase toggles at half the blink period in display ticks
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      blink_cnt     <= 14'h0000;
      blink_phase_o <= 1'b0;
    end else if (blink_rate_o == 2'h0) begin
      blink_cnt     <= 14'h0000;
      blink_phase_o <= 1'b0;
    end else if (disp_tick_i) begin
      if (blink_cnt >= 14'(((DIV_2HZ / 2) << (blink_rate_o - 2'h1)) - 1)) begin
        blink_cnt     <= 14'h0000;
        blink_phase_o <= !blink_phase_o;
      end else begin
        blink_cnt <= blink_cnt + 14'h0001;
      end
    end
  end

  // Two-entry buffer between byte intake and RAM write port
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      buf_full0 <= 1'b0;
      buf_full1 <= 1'b0;
      buf_addr0 <= '0;
      buf_addr1 <= '0;
      buf_data0 <= 8'h00;
      buf_data1 <= 8'h00;
      buf_bank0 <= 1'b0;
      buf_bank1 <= 1'b0;
    end else begin
      if (buf_full0 && ram_wr_ready_i) begin
        buf_full0 <= buf_full1 || (data_take && sel_match);
        buf_full1 <= 1'b0;
        buf_addr0 <= buf_full1 ? buf_addr1 : ram_pointer_o;
        buf_data0 <= buf_full1 ? buf_data1 : rx_byte_i;
        buf_bank0 <= buf_full1 ? buf_bank1 : in_bank;
      end else if (data_take && sel_match) begin
        if (!buf_full0) begin
          buf_full0 <= 1'b1;
          buf_addr0 <= ram_pointer_o;
          buf_data0 <= rx_byte_i;
          buf_bank0 <= in_bank;
        end else begin
          buf_full1 <= 1'b1;
          buf_addr1 <= ram_pointer_o;
          buf_data1 <= rx_byte_i;
          buf_bank1 <= in_bank;
        end
      end
    end
  end
  assign ram_wr_valid_o = buf_full0;
  assign ram_wr_addr_o  = buf_addr0;
  assign ram_wr_data_o  = buf_data0;
  assign ram_wr_bank_o  = buf_bank0;

  // Backplane sequencer; starts at phase 0 after reset so a cascade agrees
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bp_phase  <= 2'h0;
      sync_seen <= 1'b0;
    end else begin
      sync_seen <= !sync_i;
      if (!sync_i && !sync_seen && !sync_oe_o) begin
        bp_phase <= last_phase;  // Another device hit its last phase first
      end else if (disp_tick_i) begin
        bp_phase <= (bp_phase >= last_phase) ? 2'h0 : bp_phase + 2'h1;
      end
    end
  end
  assign backplane_out_o = bp_phase;

  // Open-drain sync: drive low only in the last phase, else listen
  assign sync_o    = 1'b0;
  assign sync_oe_o = (bp_phase == last_phase);

endmodule // lcdcd_decoder

// File: verilog/lcdcd_map.svh
// Offsets, opcode patterns, reset values and timing counts of the LCD command decoder
`ifndef LCDCD_MAP_SVH
`define LCDCD_MAP_SVH
`define LCDCD_OP_MODE      4'hC
`define LCDCD_OP_DEVSEL    5'h1C
`define LCDCD_OP_BANK      6'h3E
`define LCDCD_OP_BLINK     5'h1E
`define LCDCD_RAM_LOCS     7'h50
`define LCDCD_RST_MODE     2'h1
`define LCDCD_RST_RATE     2'h0
`define LCDCD_ADDR_BASE    6'h1C
`define LCDCD_DIV_2HZ      768
`define LCDCD_DIV_1HZ      1536
`define LCDCD_DIV_05HZ     3072
`define LCDCD_PHASE_TICKS  8'h01
`endif

// File: verilog/lcdcd_pkg.sv
// Types shared by the LCD command decoder
package lcdcd_pkg;
  typedef enum logic [1:0] {
    LCDCD_MUX4   = 2'b00,
    LCDCD_STATIC = 2'b01,
    LCDCD_MUX2   = 2'b10,
    LCDCD_MUX3   = 2'b11
  } lcdcd_mode_t;
  typedef enum logic [1:0] {
    LCDCD_ST_ADDR,
    LCDCD_ST_CTRL,
    LCDCD_ST_BODY,
    LCDCD_ST_IGNORE
  } lcdcd_state_t;
endpackage
